/* File: src/epa_port.sv */
// External port: address translation, word packing, selects, strobes and bus grant
//
// Implementation choices: the strobed register port and the placing of the registers.
`include "epa_regs.svh"
module epa_port (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst,
   // Register port
   input  wire logic [3:0]          regAddr,
   input  wire logic [15:0]         regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic [15:0]              regRdata_r,
   // Core request
   input  wire epa_pkg::epa_req_t   req,
   input  wire logic                reqValid,
   output logic                     reqReady_r,
   output logic                     rspValid_r,
   output logic [23:0]              rspData_r,
   // External bus pins
   output logic [21:0]              extAddr_r,
   output logic                     extAddrOe_r,
   input  wire logic [15:0]         extDataIn,
   output logic [15:0]              extDataOut_r,
   output logic [15:0]              extDataOe_r,
   output logic [3:0]               bankSelects_n_r,
   output logic                     bootSpaceSelect_n_r,
   output logic                     ioSpaceSelect_n_r,
   output logic                     rdStrobe_n_r,
   output logic                     wrStrobe_n_r,
   output logic                     ctlOe_r,
   input  wire logic                ack,
   input  wire logic                busRequest_n,
   output logic                     busGrant_n_r,
   output logic                     outputClock_r
);
   // Synchronisers for asynchronous pins
   logic [1:0]  ackSync_r, busReqSync_r;
   logic [15:0] dinMeta_r, dinSync_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ackSync_r <= 2'h3;
         busReqSync_r <= 2'h3;
         dinMeta_r <= 16'h0000;
         dinSync_r <= 16'h0000;
      end else begin
         ackSync_r <= {ackSync_r[0], ack};
         busReqSync_r <= {busReqSync_r[0], busRequest_n};
         dinMeta_r <= extDataIn;
         dinSync_r <= dinMeta_r;
      end
   end
   logic ackOk, busReqAsk;
   assign ackOk     = ackSync_r[1];
   assign busReqAsk = ~busReqSync_r[1];

   // Registers
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [5:0]  wait_r, wait_nxt;
   logic [7:0]  flagOut_r, flagOut_nxt;
   logic [15:0] rdNxt;
   always_comb begin
      ctrl_nxt    = ctrl_r;
      wait_nxt    = wait_r;
      flagOut_nxt = flagOut_r;
      if (regWr) begin
         case (regAddr)
            `EPA_OFS_CTRL:    ctrl_nxt = regWdata[7:0];
            `EPA_OFS_WAIT:    wait_nxt = regWdata[5:0];
            `EPA_OFS_FLAGOUT: flagOut_nxt = regWdata[7:0];
            default: ;
         endcase
      end
   end

   logic bws, dfs, flagEn, halfClk, ackEn;
   assign dfs     = ctrl_r[`EPA_CTRL_DFS];
   assign bws     = ctrl_r[`EPA_CTRL_BWS];
   assign flagEn  = ctrl_r[`EPA_CTRL_FLAGEN] & ~bws;
   assign halfClk = ctrl_r[`EPA_CTRL_HALFCLK];
   assign ackEn   = ctrl_r[`EPA_CTRL_ACKEN];

   // Transfer engine
   epa_pkg::epa_state_t state_r, state_nxt;
   epa_pkg::epa_req_t   cur_r, cur_nxt;
   logic [1:0]  piece_r, piece_nxt;
   logic [2:0]  wcnt_r, wcnt_nxt;
   logic [23:0] asm_r, asm_nxt;
   logic [21:0] base_r, base_nxt;

   // Pieces per word and translated base, from the live request
   logic        xfer24, fmtX2;
   logic [1:0]  lastPiece;
   logic [25:0] phys;
   always_comb begin
      xfer24 = (req.xfer != epa_pkg::EPA_XF_D16) &&
               !(req.xfer == epa_pkg::EPA_XF_D24 && !dfs);
      fmtX2  = dfs && (req.xfer == epa_pkg::EPA_XF_D16);
      phys   = {2'b00, req.addr};
      if (fmtX2) phys = {phys[24:0], 1'b0};
      if (xfer24) begin
         phys = bws ? {phys[24:0], 1'b0} : {phys[23:0], 2'b00};
      end else if (!bws) begin
         phys = {phys[24:0], 1'b0};
      end
   end
   // Last piece index of the held transfer
   logic curX24;
   assign curX24 = (cur_r.xfer != epa_pkg::EPA_XF_D16) &&
                   !(cur_r.xfer == epa_pkg::EPA_XF_D24 && !dfs);
   always_comb begin
      if (curX24) lastPiece = bws ? 2'd1 : 2'd3;
      else        lastPiece = bws ? 2'd0 : 2'd1;
   end

   // Space decode
   logic       bootHit;
   logic [5:0] selNxt;
   always_comb begin
      bootHit = 1'b0;
      if (cur_r.xfer == epa_pkg::EPA_XF_INSTR) bootHit = ctrl_r[`EPA_CTRL_PIBE];
      else if (cur_r.progMem) bootHit = ctrl_r[`EPA_CTRL_PDBE];
      else bootHit = ctrl_r[`EPA_CTRL_DDBE];
      selNxt = `EPA_SEL_IDLE;
      if (cur_r.space == epa_pkg::EPA_SP_IO) selNxt[5] = 1'b0;
      else if (cur_r.space == epa_pkg::EPA_SP_BOOT || bootHit) selNxt[4] = 1'b0;
      else selNxt[cur_r.addr[23:22]] = 1'b0;
   end

   // Bus piece for the current slot
   logic [15:0] pieceOut, dataNxt;
   always_comb begin
      pieceOut = 16'h0000;
      if (bws) begin
         if (curX24) pieceOut = (piece_r == 2'd0) ? {cur_r.wdata[7:0], 8'h00}
                                                 : cur_r.wdata[23:8];
         else if (cur_r.xfer == epa_pkg::EPA_XF_D24) pieceOut = cur_r.wdata[23:8];
         else pieceOut = cur_r.wdata[15:0];
      end else begin
         if (curX24) begin
            case (piece_r)
               2'd1:    pieceOut = {8'h00, cur_r.wdata[7:0]};
               2'd2:    pieceOut = {8'h00, cur_r.wdata[15:8]};
               2'd3:    pieceOut = {8'h00, cur_r.wdata[23:16]};
               default: pieceOut = 16'h0000;
            endcase
         end else begin
            pieceOut = (piece_r == 2'd0) ? {8'h00, cur_r.wdata[7:0]} : {8'h00, cur_r.wdata[15:8]};
            if (cur_r.xfer == epa_pkg::EPA_XF_D24)
               pieceOut = (piece_r == 2'd0) ? {8'h00, cur_r.wdata[15:8]}
                                            : {8'h00, cur_r.wdata[23:16]};
         end
      end
   end

   // Write data load in setup so they stand unchanged through the whole strobe
   assign dataNxt = (state_r == epa_pkg::EPA_SETUP) ? pieceOut : extDataOut_r;
   // Piece assembled into the word on reads
   logic [23:0] asmIn;
   always_comb begin
      asmIn = asm_r;
      if (bws) begin
         if (curX24) begin
            if (piece_r == 2'd0) asmIn[7:0] = dinSync_r[15:8];
            else asmIn[23:8] = dinSync_r;
         end else if (cur_r.xfer == epa_pkg::EPA_XF_D24) asmIn = {dinSync_r, 8'h00};
         else asmIn = {8'h00, dinSync_r};
      end else begin
         if (curX24) begin
            case (piece_r)
               2'd1:    asmIn[7:0]   = dinSync_r[7:0];
               2'd2:    asmIn[15:8]  = dinSync_r[7:0];
               2'd3:    asmIn[23:16] = dinSync_r[7:0];
               default: asmIn = asm_r;
            endcase
         end else if (cur_r.xfer == epa_pkg::EPA_XF_D24) begin
            if (piece_r == 2'd0) asmIn[15:8] = dinSync_r[7:0];
            else asmIn[23:16] = dinSync_r[7:0];
         end else begin
            if (piece_r == 2'd0) asmIn[7:0] = dinSync_r[7:0];
            else asmIn[15:8] = dinSync_r[7:0];
         end
      end
   end

   logic [2:0] waitCode;
   assign waitCode = cur_r.write ? wait_r[5:3] : wait_r[2:0];

   always_comb begin
      state_nxt = state_r;
      cur_nxt   = cur_r;
      piece_nxt = piece_r;
      wcnt_nxt  = wcnt_r;
      asm_nxt   = asm_r;
      base_nxt  = base_r;
      case (state_r)
         epa_pkg::EPA_IDLE: begin
            if (busReqAsk) state_nxt = epa_pkg::EPA_GRANT;
            else if (reqValid) begin
               cur_nxt   = req;
               base_nxt  = phys[21:0];
               piece_nxt = (xfer24 && !bws) ? 2'd1 : 2'd0;
               asm_nxt   = 24'h000000;
               state_nxt = epa_pkg::EPA_SETUP;
            end
         end
         epa_pkg::EPA_SETUP: begin
            wcnt_nxt  = waitCode;
            state_nxt = epa_pkg::EPA_STROBE;
         end
         epa_pkg::EPA_STROBE: begin
            if (wcnt_r != 3'h0) wcnt_nxt = wcnt_r - 3'h1;
            else if (!ackEn || ackOk) state_nxt = epa_pkg::EPA_HOLD;
         end
         epa_pkg::EPA_HOLD: begin
            // Two cycles: pin data reach the second synchroniser stage one cycle late
            if (wcnt_r == 3'h0) wcnt_nxt = 3'h1;
            else begin
               if (!cur_r.write) asm_nxt = asmIn;
               if (piece_r == lastPiece) state_nxt = epa_pkg::EPA_DONE;
               else begin
                  piece_nxt = piece_r + 2'd1;
                  state_nxt = epa_pkg::EPA_SETUP;
               end
            end
         end
         epa_pkg::EPA_DONE: state_nxt = epa_pkg::EPA_IDLE;
         epa_pkg::EPA_GRANT: if (!busReqAsk) state_nxt = epa_pkg::EPA_IDLE;
         default: state_nxt = epa_pkg::EPA_IDLE;
      endcase
   end

   // Pin values follow the state
   logic busy, strobeOn;
   assign busy     = (state_r == epa_pkg::EPA_SETUP) || (state_r == epa_pkg::EPA_STROBE) ||
                     (state_r == epa_pkg::EPA_HOLD);
   assign strobeOn = (state_nxt == epa_pkg::EPA_STROBE);

   logic clkDiv_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= epa_pkg::EPA_IDLE;
         cur_r <= '0;
         piece_r <= 2'd0;
         wcnt_r <= 3'h0;
         asm_r <= 24'h000000;
         base_r <= 22'h000000;
         ctrl_r <= `EPA_CTRL_RST;
         wait_r <= `EPA_WAIT_RST;
         flagOut_r <= 8'h00;
         clkDiv_r <= 1'b0;
         outputClock_r <= 1'b0;
         regRdata_r <= 16'h0000;
         reqReady_r <= 1'b0;
         rspValid_r <= 1'b0;
         rspData_r <= 24'h000000;
         extAddr_r <= 22'h000000;
         extAddrOe_r <= 1'b1;
         extDataOut_r <= 16'h0000;
         extDataOe_r <= 16'h0000;
         bankSelects_n_r <= 4'hf;
         bootSpaceSelect_n_r <= 1'b1;
         ioSpaceSelect_n_r <= 1'b1;
         rdStrobe_n_r <= 1'b1;
         wrStrobe_n_r <= 1'b1;
         ctlOe_r <= 1'b1;
         busGrant_n_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         piece_r <= piece_nxt;
         wcnt_r <= wcnt_nxt;
         asm_r <= asm_nxt;
         base_r <= base_nxt;
         ctrl_r <= ctrl_nxt;
         wait_r <= wait_nxt;
         flagOut_r <= flagOut_nxt;
         // Half rate toggles every other cycle
         clkDiv_r <= ~clkDiv_r;
         if (!halfClk || clkDiv_r) outputClock_r <= ~outputClock_r;
         regRdata_r <= rdNxt;
         reqReady_r <= (state_nxt == epa_pkg::EPA_IDLE) && !busReqAsk;
         rspValid_r <= (state_nxt == epa_pkg::EPA_DONE) && !cur_r.write;
         if (state_nxt == epa_pkg::EPA_DONE) rspData_r <= asm_nxt;
         extAddr_r <= (state_nxt == epa_pkg::EPA_SETUP) ? pieceAddrN() : extAddr_r;
         extDataOut_r[7:0] <= dataNxt[7:0];
         extDataOut_r[15:8] <= flagEn ? flagOut_r : dataNxt[15:8];
         extDataOe_r[7:0] <= {8{cur_nxt.write && (state_nxt inside
                             {epa_pkg::EPA_SETUP, epa_pkg::EPA_STROBE, epa_pkg::EPA_HOLD})}};
         extDataOe_r[15:8] <= flagEn ? 8'hff : {8{cur_nxt.write && bws && (state_nxt inside
                             {epa_pkg::EPA_SETUP, epa_pkg::EPA_STROBE, epa_pkg::EPA_HOLD})}};
         // Selects held across every piece of the word
         {ioSpaceSelect_n_r, bootSpaceSelect_n_r, bankSelects_n_r} <=
            (state_nxt inside {epa_pkg::EPA_SETUP, epa_pkg::EPA_STROBE, epa_pkg::EPA_HOLD})
            ? selNxtN() : `EPA_SEL_IDLE;
         rdStrobe_n_r <= ~(strobeOn && !cur_nxt.write);
         wrStrobe_n_r <= ~(strobeOn && cur_nxt.write);
         extAddrOe_r <= (state_nxt != epa_pkg::EPA_GRANT);
         ctlOe_r <= (state_nxt != epa_pkg::EPA_GRANT);
         busGrant_n_r <= (state_nxt != epa_pkg::EPA_GRANT);
      end
   end

   // Next-state views of address and select for the pin registers
   function automatic logic [21:0] pieceAddrN();
      logic [21:0] a;
      a = (state_r == epa_pkg::EPA_IDLE) ? base_nxt + {20'h00000, piece_nxt}
                                         : base_r + {20'h00000, piece_nxt};
      return a;
   endfunction : pieceAddrN
   function automatic logic [5:0] selNxtN();
      return (state_r == epa_pkg::EPA_IDLE) ? {~(req.space == epa_pkg::EPA_SP_IO),
             ~(req.space == epa_pkg::EPA_SP_BOOT || (req.xfer == epa_pkg::EPA_XF_INSTR ?
             ctrl_r[`EPA_CTRL_PIBE] : req.progMem ? ctrl_r[`EPA_CTRL_PDBE] :
             ctrl_r[`EPA_CTRL_DDBE])) || req.space == epa_pkg::EPA_SP_IO,
             selBank(req)} : selNxt;
   endfunction : selNxtN
   function automatic logic [3:0] selBank(input epa_pkg::epa_req_t r);
      logic [3:0] s;
      logic       boot;
      boot = (r.xfer == epa_pkg::EPA_XF_INSTR) ? ctrl_r[`EPA_CTRL_PIBE] :
             r.progMem ? ctrl_r[`EPA_CTRL_PDBE] : ctrl_r[`EPA_CTRL_DDBE];
      s = 4'hf;
      if (r.space == epa_pkg::EPA_SP_MEM && !boot) s[r.addr[23:22]] = 1'b0;
      return s;
   endfunction : selBank

   // Read data for the register port
   always_comb begin
      rdNxt = 16'h0000;
      if (regRd) begin
         case (regAddr)
            `EPA_OFS_CTRL:    rdNxt = {8'h00, ctrl_r};
            `EPA_OFS_STAT:    rdNxt = {12'h000, !busGrant_n_r, piece_r, state_r == epa_pkg::EPA_IDLE
                                       ? 1'b0 : 1'b1};
            `EPA_OFS_WAIT:    rdNxt = {10'h000, wait_r};
            `EPA_OFS_RDATA:   rdNxt = rspData_r[15:0];
            `EPA_OFS_FLAGOUT: rdNxt = {8'h00, flagOut_r};
            `EPA_OFS_FLAGIN:  rdNxt = {8'h00, dinSync_r[15:8]};
            default:          rdNxt = 16'h0000;
         endcase
      end
   end

   // Checks
   sequence grantReq_s;
      (state_r == epa_pkg::EPA_IDLE) && busReqAsk;
   endsequence
   grant_next_a: assert property (@(posedge core_clk) disable iff (rst)
      grantReq_s |=> !busGrant_n_r && !extAddrOe_r) else $error("grant not given");
   strobe_after_sel_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(rdStrobe_n_r) |-> $past(({ioSpaceSelect_n_r, bootSpaceSelect_n_r,
      bankSelects_n_r}) != `EPA_SEL_IDLE)) else $error("strobe before select");
   sel_held_a: assert property (@(posedge core_clk) disable iff (rst)
      !rdStrobe_n_r |-> ({ioSpaceSelect_n_r, bootSpaceSelect_n_r, bankSelects_n_r}
      != `EPA_SEL_IDLE)) else $error("select dropped in access");
   boot_redirect_a: assert property (@(posedge core_clk) disable iff (rst)
      (!wrStrobe_n_r && ctrl_r[`EPA_CTRL_DDBE] && !cur_r.progMem &&
      cur_r.xfer != epa_pkg::EPA_XF_INSTR && cur_r.space == epa_pkg::EPA_SP_MEM)
      |-> !bootSpaceSelect_n_r && bankSelects_n_r == 4'hf) else $error("no boot redirect");
   one_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
      !(~rdStrobe_n_r && ~wrStrobe_n_r)) else $error("both strobes low");
   wait_len_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == epa_pkg::EPA_SETUP && !ackEn && waitCode == 3'h2) |=>
      (state_r == epa_pkg::EPA_STROBE) [*3] ##1 state_r == epa_pkg::EPA_HOLD)
      else $error("waitstate count wrong");
   ack_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == epa_pkg::EPA_STROBE && wcnt_r == 3'h0 && ackEn && !ackOk) |=>
      state_r == epa_pkg::EPA_STROBE) else $error("ack ignored");
   clk_full_a: assert property (@(posedge core_clk) disable iff (rst)
      (!halfClk && $past(!halfClk) && !$past(rst)) |-> outputClock_r != $past(outputClock_r))
      else $error("output clock stalled");
endmodule : epa_port

/* File: src/epa_regs.svh */
// Register offsets, field positions, reset values and address and select constants of the external port
`ifndef EPA_REGS_SVH
`define EPA_REGS_SVH
`define EPA_OFS_CTRL      4'h0
`define EPA_OFS_STAT      4'h1
`define EPA_OFS_WAIT      4'h2
`define EPA_OFS_RDATA     4'h3
`define EPA_OFS_FLAGOUT   4'h4
`define EPA_OFS_FLAGIN    4'h5
`define EPA_CTRL_PIBE     0
`define EPA_CTRL_PDBE     1
`define EPA_CTRL_DDBE     2
`define EPA_CTRL_DFS      3
`define EPA_CTRL_BWS      4
`define EPA_CTRL_FLAGEN   5
`define EPA_CTRL_HALFCLK  6
`define EPA_CTRL_ACKEN    7
`define EPA_CTRL_RST      8'h00
`define EPA_WAIT_RST      6'h00
`define EPA_ADDR_W        22
`define EPA_SEL_IDLE      6'h3f
`define EPA_BANK_SHIFT    22
`endif

/* File: src/epa_pkg.sv */
// Types shared by the external port address and packing logic
package epa_pkg;
   typedef enum logic [1:0] {
      EPA_XF_INSTR = 2'b00,
      EPA_XF_D24   = 2'b01,
      EPA_XF_D16   = 2'b10
   } epa_xfer_t;

   typedef enum logic [1:0] {
      EPA_SP_MEM  = 2'b00,
      EPA_SP_BOOT = 2'b01,
      EPA_SP_IO   = 2'b10
   } epa_space_t;

   typedef struct packed {
      logic       write;
      epa_space_t space;
      epa_xfer_t  xfer;
      logic       progMem;
      logic [23:0] addr;
      logic [23:0] wdata;
   } epa_req_t;

   typedef enum logic [2:0] {
      EPA_IDLE   = 3'b000,
      EPA_SETUP  = 3'b001,
      EPA_STROBE = 3'b010,
      EPA_HOLD   = 3'b011,
      EPA_DONE   = 3'b100,
      EPA_GRANT  = 3'b101
   } epa_state_t;
endpackage : epa_pkg

/* File: sim/epa_mem_model.sv */
// Behavioural far-side memory for the external port: four banks, boot and I/O space
module epa_mem_model (
   // Clock and wait control
   input  wire logic        core_clk,
   input  wire logic        slow,
   // Pins driven by the port
   input  wire logic [21:0] extAddr,
   input  wire logic [15:0] extDataOut,
   input  wire logic [3:0]  bankSel_n,
   input  wire logic        bootSel_n,
   input  wire logic        ioSel_n,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   // Answers to the port
   output logic [15:0]      dataIn,
   output logic             ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [int];
   logic [15:0] wrVal, lastOut = 16'h5a5a;
   logic        wrPend = 1'b0;
   int          key, wrKey, prevKey = 0, lowCnt = 0, selErr = 0, nStb = 0;
   // Space code above the 22 address bits keeps the spaces apart
   always @* begin
      key = int'(extAddr);
      if (!bootSel_n) key += 4 << 22;
      else if (!ioSel_n) key += 5 << 22;
      else for (int i = 0; i < 4; i++) if (!bankSel_n[i]) key += i << 22;
   end
   // Data show only while read is low; else an inverted pattern, never a held value
   always @(rd_n, key) begin
      if (!rd_n) begin
         dataIn = mem[key];
         lastOut = dataIn;
      end else begin
         dataIn = ~lastOut;
      end
   end
   // Sampled mid-cycle so the port's edge updates never race the model
   always @(negedge core_clk) begin
      if (!rd_n || !wr_n) begin
         if (lowCnt == 0) nStb++;
         if (key != prevKey || $countones({bankSel_n, bootSel_n, ioSel_n}) != 5) selErr++;
         lowCnt++;
      end else begin
         lowCnt = 0;
      end
      if (!wr_n) begin
         wrPend = 1'b1;
         wrKey = key;
         wrVal = extDataOut;
      end else if (wrPend) begin
         mem[wrKey] = wrVal;
         wrPend = 1'b0;
      end
      prevKey = key;
   end
   // Slow mode holds the access off for twelve cycles, longer than the largest wait count
   assign ack = !(slow && (!rd_n || !wr_n) && lowCnt < 12);
endmodule : epa_mem_model

/* File: sim/external_port_addr_packing_tb.sv */
// Self-checking bench for the external port against a behavioural packing model
`define CHK(n, e, g) cmp(n, 24'(e), 24'(g));
module external_port_addr_packing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rst = 1, regWr = 0, regRd = 0, reqValid = 0, slow = 0, busRequest_n = 1;
   logic [3:0]  regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0000, regRdata_r, extDataIn, extDataOut_r, extDataOe_r, d;
   epa_pkg::epa_req_t req = '0;
   logic reqReady_r, rspValid_r, extAddrOe_r, bootSpaceSelect_n_r, ioSpaceSelect_n_r;
   logic rdStrobe_n_r, wrStrobe_n_r, ctlOe_r, ack, busGrant_n_r, outputClock_r, oc;
   logic [23:0] rspData_r;
   logic [21:0] extAddr_r;
   logic [3:0]  bankSelects_n_r;
   int          mismatches = 0, n_checks = 0, ctrl, k, nt[2];
   epa_port i_epa_port (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .req(req), .reqValid(reqValid),
      .reqReady_r(reqReady_r), .rspValid_r(rspValid_r), .rspData_r(rspData_r),
      .extAddr_r(extAddr_r), .extAddrOe_r(extAddrOe_r), .extDataIn(extDataIn),
      .extDataOut_r(extDataOut_r), .extDataOe_r(extDataOe_r), .bankSelects_n_r(bankSelects_n_r),
      .bootSpaceSelect_n_r(bootSpaceSelect_n_r), .ioSpaceSelect_n_r(ioSpaceSelect_n_r),
      .rdStrobe_n_r(rdStrobe_n_r), .wrStrobe_n_r(wrStrobe_n_r), .ctlOe_r(ctlOe_r), .ack(ack),
      .busRequest_n(busRequest_n), .busGrant_n_r(busGrant_n_r), .outputClock_r(outputClock_r));
   epa_mem_model i_epa_mem_model (.core_clk(core_clk), .slow(slow), .extAddr(extAddr_r),
      .extDataOut(extDataOut_r), .bankSel_n(bankSelects_n_r), .bootSel_n(bootSpaceSelect_n_r),
      .ioSel_n(ioSpaceSelect_n_r), .rd_n(rdStrobe_n_r), .wr_n(wrStrobe_n_r), .dataIn(extDataIn),
      .ack(ack));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         mismatches++;
         wrap_up();
      end
   endtask : tmo
   task automatic regW(input logic [3:0] a, input logic [15:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : regW
   task automatic regR(input logic [3:0] a, output logic [15:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 v = regRdata_r;
   endtask : regR
   // Request held until the edge that samples ready high
   task automatic xfer(input logic w, input int sp, xf, pm, a, wd, output logic [23:0] r);
      int n;
      @(posedge core_clk);
      req <= '{w, epa_pkg::epa_space_t'(sp[1:0]), epa_pkg::epa_xfer_t'(xf[1:0]), pm[0],
               a[23:0], wd[23:0]};
      reqValid <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end while (reqReady_r !== 1'b1 && n < 50);
      reqValid <= 1'b0;
      tmo(n, 50);
      n = 0;
      do begin @(posedge core_clk); #1 n++; end
         while (!(w ? reqReady_r === 1'b1 : rspValid_r === 1'b1) && n < 400);
      tmo(n, 400);
      r = rspData_r;
   endtask : xfer
   // Writes (or preloads for fetches) one word, checks the pieces, then reads it back
   task automatic run(input int sp, xf, pm, a);
      int dfs, bws, t24, ph, v, cd, n, base, kk;
      int pc [$];
      logic [23:0] got;
      dfs = ctrl[3];
      bws = ctrl[4];
      t24 = xf == 0 || (xf == 1 && dfs);
      ph = (xf == 2 && dfs ? 2 : 1) * ((t24 ? 4 : 2) / (bws ? 2 : 1)) * a;
      v = $urandom;
      v = xf == 1 && !dfs ? v[23:8] : t24 ? v[23:0] : v[15:0];
      if (bws && t24) pc = '{v[7:0] << 8, v[23:8]};
      else if (bws) pc = '{v};
      else if (t24) pc = '{v[7:0], v[15:8], v[23:16]};
      else pc = '{v[7:0], v[15:8]};
      base = ph + (t24 && !bws);
      cd = sp == 1 ? 4 : sp == 2 ? 5 : (xf == 0 ? ctrl[0] : pm ? ctrl[1] : ctrl[2]) ? 4 : a[23:22];
      n = i_epa_mem_model.nStb;
      if (xf != 0) xfer(1'b1, sp, xf, pm, a, v << (xf == 1 && !dfs ? 8 : 0), got);
      tick(2);
      `CHK("write pieces", xf ? pc.size() : 0, i_epa_mem_model.nStb - n)
      for (int i = 0; i < pc.size(); i++) begin
         kk = ((base + i) & 32'h3fffff) + (cd << 22);
         if (xf == 0) i_epa_mem_model.mem[kk] = pc[i][15:0];
         else `CHK("piece", pc[i], bws ? i_epa_mem_model.mem[kk] : i_epa_mem_model.mem[kk][7:0])
      end
      n = i_epa_mem_model.nStb;
      xfer(1'b0, sp, xf, pm, a, 0, got);
      `CHK("read pieces", pc.size(), i_epa_mem_model.nStb - n)
      `CHK("word", xf == 1 && !dfs ? v << 8 : v, got)
   endtask : run
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   initial begin
      void'($urandom(7));
      tick(3);
      rst <= 1'b0;
      tick(2);
      regR(4'h0, d);
      `CHK("ctrl reset", 16'h0000, d)
      regR(4'h2, d);
      `CHK("wait reset", 16'h0000, d)
      regW(4'h2, 16'h0012);
      regW(4'hf, 16'hffff);
      regR(4'hf, d);
      `CHK("unmapped", 16'h0000, d)
      for (int b = 0; b < 4; b++) begin
         ctrl = (b << 3) | (b < 2 ? 32'h20 : 0);
         regW(4'h0, ctrl[15:0]);
         regR(4'h0, d);
         `CHK("ctrl", ctrl, d)
         run(0, 1, 1, $urandom);
         run(0, 2, 0, $urandom);
         run(0, 0, 0, $urandom);
         run(2, 2, 0, $urandom);
         run(1, 1, 1, $urandom);
      end
      // Longest waits and a stalling far side on the redirect cases
      regW(4'h2, 16'h003f);
      regR(4'h2, d);
      `CHK("wait", 16'h003f, d)
      slow <= 1'b1;
      for (int b = 0; b < 3; b++) begin
         ctrl = 32'h98 | (1 << b);
         regW(4'h0, ctrl[15:0]);
         run(0, 1, 1, $urandom);
         run(0, 2, 0, $urandom);
         run(0, 0, 0, $urandom);
      end
      run(1, 1, 1, 32'h800000);
      `CHK("select order", 0, i_epa_mem_model.selErr)
      @(posedge core_clk);
      busRequest_n <= 1'b0;
      k = 0;
      do begin @(posedge core_clk); #1 k++; end while (busGrant_n_r !== 1'b0 && k < 10);
      tmo(k, 10);
      `CHK("grant", 0, busGrant_n_r)
      `CHK("released", 0, {extAddrOe_r, ctlOe_r, |extDataOe_r})
      busRequest_n <= 1'b1;
      tick(5);
      `CHK("grant end", 1, busGrant_n_r)
      for (int h = 0; h < 2; h++) begin
         regW(4'h0, 16'(h << 6));
         tick(4);
         #1;
         nt[h] = 0;
         repeat (32) begin
            oc = outputClock_r;
            @(posedge core_clk);
            #1 if (outputClock_r !== oc) nt[h]++;
         end
      end
      `CHK("clock ratio", nt[0], 2 * nt[1])
      regW(4'h0, 16'h0020);
      regW(4'h4, 16'h00a5);
      tick(2);
      #1 `CHK("flag pins", 16'hffa5, {extDataOe_r[15:8], extDataOut_r[15:8]})
      wrap_up();
   end
   initial begin
      #2500000;
      mismatches++;
      wrap_up();
   end
endmodule : external_port_addr_packing_tb
